// ==== inc/agio_pkg.sv ====
`include "agio_regs.svh"

// ----------------------------------------------------------------------------
// Shared types of the digital line groups
// ----------------------------------------------------------------------------
package agio_pkg;

    // Eight lines as one vector, bit n is line n.
    typedef logic [`AGIO_LINE_COUNT-1:0] agio_line_t;

    // Direction settings of the two groups.
    typedef logic [`AGIO_DIR_WIDTH-1:0] agio_dir_t;

    // Bus words.
    typedef logic [`AGIO_BUS_DATA_WIDTH-1:0] agio_word_t;
    typedef logic [`AGIO_BUS_ADDR_WIDTH-1:0] agio_addr_t;
    typedef logic [`AGIO_BUS_SEL_WIDTH-1:0] agio_sel_t;

    // Which register a bus access selects.
    typedef enum logic [1:0] {
        AGIO_REG_NONE = 2'h0,
        AGIO_REG_DIR = 2'h1,
        AGIO_REG_DATA = 2'h3
    } agio_reg_e;

endpackage : agio_pkg

// ==== inc/agio_reg_if.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Register access between the bus slave and the line logic
// ----------------------------------------------------------------------------
interface agio_reg_if;
    import agio_pkg::*;

    logic wr_stb;
    agio_reg_e reg_sel;
    logic lane0;
    agio_line_t wdata;
    agio_word_t rdata;

    modport slave (output wr_stb, output reg_sel, output lane0, output wdata, input rdata);
    modport regs (input wr_stb, input reg_sel, input lane0, input wdata, output rdata);

endinterface : agio_reg_if

// ==== inc/agio_regs.svh ====
`ifndef AGIO_REGS_SVH
`define AGIO_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------

// Register indices; the byte address on the bus is four times the index.
`define AGIO_DIR_IDX 47100
`define AGIO_DATA_IDX 47110
`define AGIO_DIR_ADDR (`AGIO_DIR_IDX * 4)
`define AGIO_DATA_ADDR (`AGIO_DATA_IDX * 4)

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------

// Direction register: one bit per four-line group, set means output.
`define AGIO_DIR_LOWER_BIT 0
`define AGIO_DIR_UPPER_BIT 1
`define AGIO_DIR_WIDTH 2
`define AGIO_DIR_RESET 2'h0
`define AGIO_PATTERN_RESET 8'h00

// Line geometry.
`define AGIO_LINE_COUNT 8
`define AGIO_GROUP_WIDTH 4

// Bus geometry.
`define AGIO_BUS_DATA_WIDTH 32
`define AGIO_BUS_ADDR_WIDTH 32
`define AGIO_BUS_SEL_WIDTH 4

`endif

// ==== rtl/agio_top.sv ====
`timescale 1ns/1ps
`include "agio_regs.svh"


// ----------------------------------------------------------------------------
// Asynchronous digital line groups
// ----------------------------------------------------------------------------
module agio_top
    import agio_pkg::*;
#(
    parameter int unsigned LINE_COUNT = `AGIO_LINE_COUNT,
    parameter int unsigned GROUP_WIDTH = `AGIO_GROUP_WIDTH
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire agio_pkg::agio_addr_t wb_adr_i,
    input wire agio_pkg::agio_sel_t wb_sel_i,
    input wire agio_pkg::agio_word_t wb_dat_i,
    output logic wb_ack_o,
    output agio_pkg::agio_word_t wb_dat_o,
    // Digital lines, three signals per two-way pin.
    input wire agio_pkg::agio_line_t io_line_i,
    output agio_pkg::agio_line_t io_line_o,
    output agio_pkg::agio_line_t io_line_oe_o
);
    import agio_pkg::*;

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    // Expands the two group direction bits to one enable bit per line.
    function automatic agio_line_t group_mask(input agio_dir_t dir);
        agio_line_t m;
        m = '0;
        for (int i = 0; i < LINE_COUNT; i++) begin
            m[i] = dir[i / GROUP_WIDTH];
        end
        return m;
    endfunction : group_mask

    // Merges new bits into old ones where the mask is set.
    function automatic agio_line_t merge_masked(input agio_line_t old_v, input agio_line_t new_v,
                                                input agio_line_t m);
        return (old_v & ~m) | (new_v & m);
    endfunction : merge_masked

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------

    agio_reg_if rif ();

    agio_dir_t dir_r;
    agio_dir_t dir_nxt;
    agio_line_t pattern_r;
    agio_line_t pattern_nxt;
    agio_line_t oe_r;
    agio_line_t oe_nxt;
    agio_line_t out_r;
    agio_line_t out_nxt;
    agio_line_t sync1_r;
    agio_line_t sync1_nxt;
    agio_line_t sync2_r;
    agio_line_t sync2_nxt;
    agio_line_t dir_wmask;
    agio_line_t out_mask;
    agio_dir_t dir_wval;
    logic dir_we;
    logic data_we;

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------

    // The slave answers every access one cycle after it is raised.
    agio_wb_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o),
        .rif(rif.slave)
    );

    // ------------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------------

    // Only byte lane 0 carries settings and line data; upper lanes are dropped.
    always_comb begin
        dir_we = rif.wr_stb & rif.lane0 & (rif.reg_sel == AGIO_REG_DIR);
        data_we = rif.wr_stb & rif.lane0 & (rif.reg_sel == AGIO_REG_DATA);
        dir_wval = '0;
        dir_wval[`AGIO_DIR_LOWER_BIT] = rif.wdata[`AGIO_DIR_LOWER_BIT];
        dir_wval[`AGIO_DIR_UPPER_BIT] = rif.wdata[`AGIO_DIR_UPPER_BIT];
    end

    // ------------------------------------------------------------------------
    // Direction register
    // ------------------------------------------------------------------------

    // Both group settings are taken from one write, each on its own bit.
    always_comb begin
        dir_nxt = dir_r;
        if (dir_we) begin
            dir_nxt = dir_wval;
        end
    end

    // Holds the direction; reset leaves both groups as inputs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_r <= `AGIO_DIR_RESET;
        end else begin
            dir_r <= dir_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Output pattern
    // ------------------------------------------------------------------------

    // Bits written for groups that are inputs leave the stored pattern alone.
    always_comb begin
        dir_wmask = group_mask(dir_r);
        pattern_nxt = pattern_r;
        if (data_we) begin
            pattern_nxt = merge_masked(pattern_r, rif.wdata, dir_wmask);
        end
    end

    // Pattern changes only on a software write or on reset, never on any other event.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pattern_r <= `AGIO_PATTERN_RESET;
        end else begin
            pattern_r <= pattern_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------

    // Enables and levels follow the registers of the next cycle, so both
    // come straight from flip-flops and change on the same edge.
    always_comb begin
        out_mask = group_mask(dir_nxt);
        oe_nxt = out_mask;
        out_nxt = pattern_nxt & out_mask;
    end

    // Pin output registers; nothing is driven while in reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_r <= '0;
            out_r <= '0;
        end else begin
            oe_r <= oe_nxt;
            out_r <= out_nxt;
        end
    end

    assign io_line_o = out_r;
    assign io_line_oe_o = oe_r;

    // ------------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------------

    // Pin levels pass two flip-flops before the read path looks at them.
    always_comb begin
        sync1_nxt = io_line_i;
        sync2_nxt = sync1_r;
    end

    // Synchroniser stages; the first is read by the second alone.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------

    // Line reads show the pins themselves, so outputs read back as driven.
    always_comb begin
        rif.rdata = '0;
        unique case (rif.reg_sel)
            AGIO_REG_DIR: begin
                rif.rdata[`AGIO_DIR_WIDTH-1:0] = dir_r;
            end
            AGIO_REG_DATA: begin
                rif.rdata[`AGIO_LINE_COUNT-1:0] = sync2_r;
            end
            AGIO_REG_NONE: begin
                rif.rdata = '0;
            end
            default: begin
                rif.rdata = '0;
            end
        endcase
    end

endmodule : agio_top

// ==== rtl/agio_wb_slave.sv ====
`timescale 1ns/1ps
`include "agio_regs.svh"

// ----------------------------------------------------------------------------
// Classic Wishbone slave with one wait state
// ----------------------------------------------------------------------------
module agio_wb_slave
    import agio_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire agio_pkg::agio_addr_t wb_adr_i,
    input wire agio_pkg::agio_sel_t wb_sel_i,
    input wire agio_pkg::agio_word_t wb_dat_i,
    output logic wb_ack_o,
    output agio_pkg::agio_word_t wb_dat_o,
    // Register side.
    agio_reg_if.slave rif
);
    import agio_pkg::*;

    logic ack_r;
    logic ack_nxt;
    agio_word_t dat_r;
    agio_word_t dat_nxt;
    logic req;

    // Address decode; unmapped addresses select nothing and read as zero.
    always_comb begin
        req = wb_cyc_i & wb_stb_i;
        if (wb_adr_i == agio_addr_t'(`AGIO_DIR_ADDR)) begin
            rif.reg_sel = AGIO_REG_DIR;
        end else if (wb_adr_i == agio_addr_t'(`AGIO_DATA_ADDR)) begin
            rif.reg_sel = AGIO_REG_DATA;
        end else begin
            rif.reg_sel = AGIO_REG_NONE;
        end
        rif.lane0 = wb_sel_i[0];
        rif.wdata = wb_dat_i[`AGIO_LINE_COUNT-1:0];
        // The write lands on the edge at which the master sees ack.
        rif.wr_stb = req & wb_we_i & ack_r;
    end

    // Ack rises one cycle after the request and falls in the next cycle.
    always_comb begin
        ack_nxt = req & ~ack_r;
        dat_nxt = dat_r;
        if (req & ~ack_r) begin
            dat_nxt = wb_we_i ? '0 : rif.rdata;
        end
    end

    // Handshake registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

endmodule : agio_wb_slave

// ==== tb/agio_checker.sv ====
`timescale 1ns/1ps
`include "agio_regs.svh"

// ------------------------------
// Port checks of the line groups
// ------------------------------
module agio_checker
    import agio_pkg::*;
#(
    parameter int unsigned LINE_COUNT = 8,
    parameter int unsigned GROUP_WIDTH = 4
) (
    // Clock, reset and bus.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire agio_pkg::agio_addr_t wb_adr_i,
    input wire agio_pkg::agio_sel_t wb_sel_i,
    input wire agio_pkg::agio_word_t wb_dat_i,
    input wire logic wb_ack_o,
    input wire agio_pkg::agio_word_t wb_dat_o,
    // Lines.
    input wire agio_pkg::agio_line_t io_line_i,
    input wire agio_pkg::agio_line_t io_line_o,
    input wire agio_pkg::agio_line_t io_line_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr_dir;
    logic wr_dat;
    logic rd_dir;
    logic rd_dat;
    agio_line_t pin_d1_r;
    logic [2:0] quiet_r;
    logic [2:0] quiet_nxt;
    // Register strobes at the answering edge.
    assign wr_dir = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `AGIO_DIR_ADDR;
    assign wr_dat = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `AGIO_DATA_ADDR;
    assign rd_dir = wb_ack_o && !wb_we_i && wb_adr_i == `AGIO_DIR_ADDR;
    assign rd_dat = wb_ack_o && !wb_we_i && wb_adr_i == `AGIO_DATA_ADDR;
    // Counts edges with quiet pins, so a read may be judged past the synchroniser.
    always_comb begin
        quiet_nxt = (io_line_i != pin_d1_r) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
    end
    // The quiet count starts from zero at reset, so it never carries an unknown.
    always_ff @(posedge clk_i) begin
        pin_d1_r <= io_line_i;
        if (rst_i) begin
            quiet_r <= 3'h0;
        end else begin
            quiet_r <= quiet_nxt;
        end
    end
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
    a_ack_caused: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_group_whole: assert property (
        io_line_oe_o[GROUP_WIDTH-1:0] inside {4'h0, 4'hF} &&
        io_line_oe_o[LINE_COUNT-1:GROUP_WIDTH] inside {4'h0, 4'hF})
        else $error("group split");
    a_dir_apply: assert property (wr_dir |=> io_line_oe_o ==
        {{4{$past(wb_dat_i[1])}}, {4{$past(wb_dat_i[0])}}})
        else $error("direction not applied");
    a_data_apply: assert property (wr_dat |=>
        io_line_o == ($past(wb_dat_i[7:0]) & io_line_oe_o))
        else $error("pattern not applied");
    a_lines_held: assert property (!(wb_ack_o && wb_we_i) |=>
        $stable(io_line_o) && $stable(io_line_oe_o))
        else $error("lines changed by themselves");
    a_dir_readback: assert property (rd_dir |->
        wb_dat_o == {30'h0, io_line_oe_o[4], io_line_oe_o[0]})
        else $error("direction read wrong");
    a_read_pins: assert property (rd_dat && quiet_r >= 3'h5 |->
        wb_dat_o == {24'h0, io_line_i})
        else $error("pin read wrong");
    a_reset_input: assert property (disable iff (1'b0) rst_i |=> io_line_oe_o == 8'h00)
        else $error("lines driven after reset");
    c_mixed: cover property (io_line_oe_o == 8'h0F);
    c_pin_read: cover property (rd_dat && quiet_r >= 3'h5);
    c_all_out: cover property (io_line_oe_o == 8'hFF);
endmodule : agio_checker

bind agio_top agio_checker #(.LINE_COUNT(LINE_COUNT), .GROUP_WIDTH(GROUP_WIDTH)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .io_line_i(io_line_i), .io_line_o(io_line_o),
    .io_line_oe_o(io_line_oe_o));

// ==== tb/agio_ext_model.sv ====
`timescale 1ns/1ps

// ------------------------------
// Far equipment on the lines
// ------------------------------
module agio_ext_model
    import agio_pkg::*;
(
    // Board side and far side levels.
    input wire agio_pkg::agio_line_t io_line_o,
    input wire agio_pkg::agio_line_t io_line_oe_o,
    input wire agio_pkg::agio_line_t ext_pat_i,
    // Resolved wire back into the board.
    output agio_pkg::agio_line_t wire_o
);
    // The equipment drives only lines that the board leaves as inputs.
    assign wire_o = (io_line_o & io_line_oe_o) | (ext_pat_i & ~io_line_oe_o);
endmodule : agio_ext_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "agio_regs.svh"

// ------------------------------
// Register-level tests
// ------------------------------
module testbench;
    import agio_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    agio_addr_t wb_adr_i = '0;
    agio_sel_t wb_sel_i = '0;
    agio_word_t wb_dat_i = '0;
    logic wb_ack_o;
    agio_word_t wb_dat_o;
    agio_line_t io_line_i;
    agio_line_t io_line_o;
    agio_line_t io_line_oe_o;
    agio_line_t ext = 8'h3C;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    // Clock of 40 ns.
    always #20 clk_i = ~clk_i;

    agio_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .io_line_i(io_line_i), .io_line_o(io_line_o),
        .io_line_oe_o(io_line_oe_o));
    agio_ext_model u_ext (.io_line_o(io_line_o), .io_line_oe_o(io_line_oe_o), .ext_pat_i(ext),
        .wire_o(io_line_i));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // Cuts a hang short.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end

    task automatic check(input string what, input agio_word_t seen, input agio_word_t exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One classic cycle; holds the request until ack is sampled high.
    task automatic xfer(input logic we, input agio_addr_t a, input agio_word_t d,
                        input agio_sel_t s, output agio_word_t q);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask : xfer

    // Lets the pins pass the input synchroniser.
    task automatic settle();
        repeat (8) @(negedge clk_i);
    endtask : settle

    initial begin
        agio_word_t q;
        agio_line_t o;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        check("oe", 32'(io_line_oe_o), 32'h0);
        xfer(1'b0, `AGIO_DATA_ADDR, 32'h0, 4'hF, q);
        check("pins", q, 32'h3C);
        $display("test reset done");
        for (int d = 0; d < 4; d++) begin
            xfer(1'b1, `AGIO_DIR_ADDR, 32'(d & 1) | 32'(d & 2), 4'hF, q);
            xfer(1'b1, `AGIO_DATA_ADDR, 32'hDEADBEA5, 4'hF, q);
            settle();
            o = {{4{d[1]}}, {4{d[0]}}};
            check("oe low", 32'(io_line_oe_o[3:0]), 32'(o[3:0]));
            check("oe high", 32'(io_line_oe_o[7:4]), 32'(o[7:4]));
            check("out", 32'(io_line_o), 32'(8'hA5 & o));
            xfer(1'b0, `AGIO_DIR_ADDR, 32'h0, 4'hF, q);
            check("dir", q, 32'(d));
            xfer(1'b0, `AGIO_DATA_ADDR, 32'h0, 4'hF, q);
            check("pins", q, 32'((8'hA5 & o) | (ext & ~o)));
        end
        $display("test directions done");
        xfer(1'b1, `AGIO_DATA_ADDR, 32'h11, 4'hE, q);
        xfer(1'b1, 32'h100, 32'h0, 4'hF, q);
        settle();
        check("out", 32'(io_line_o), 32'hA5);
        xfer(1'b0, 32'h100, 32'h0, 4'hF, q);
        check("unmapped", q, 32'h0);
        xfer(1'b1, `AGIO_DIR_ADDR, 32'h1, 4'hF, q);
        @(posedge clk_i);
        ext <= 8'h96;
        settle();
        check("out", 32'(io_line_o), 32'h05);
        xfer(1'b0, `AGIO_DATA_ADDR, 32'h0, 4'hF, q);
        check("pins", q, 32'h95);
        $display("test refusals done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        check("oe", 32'(io_line_oe_o), 32'h0);
        xfer(1'b0, `AGIO_DIR_ADDR, 32'h0, 4'hF, q);
        check("dir", q, 32'h0);
        // Turning both groups to outputs now shows the cleared pattern.
        xfer(1'b1, `AGIO_DIR_ADDR, 32'h3, 4'hF, q);
        settle();
        check("oe", 32'(io_line_oe_o), 32'hFF);
        check("out", 32'(io_line_o), 32'h0);
        xfer(1'b0, `AGIO_DATA_ADDR, 32'h0, 4'hF, q);
        check("pins", q, 32'h0);
        $display("test second reset done");
        conclude();
    end
endmodule : testbench
